// ### rtl/eprom_host.sv
// host controller: reads, signature reads and byte programming of a 32k x 8 uv eprom
`timescale 1ns/1ps
// How it works
// - signature: select and enable low, id bit at high voltage, rest low
// - programming entry: select, enable high, then low supply, then vpp
// - stable address and data, then select pulses low to program
// - verify after each pulse: select high, enable low, compare byte except after the overprogram pulse
// - fast pulses are 100 us low on device-select
// - adaptive initial pulses are 1 ms long
// - adaptive overprogram pulse lies between 2.85 and 78.5 ms
// - fast scheme is the default; adaptive chosen by input
// - low supply up before vpp, down after vpp
// - verify cycle is only used inside programming
module eprom_host
   import eprom_host_pkg::*;
(
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst_n,
   // user request
   input wire logic req_valid,
   input wire logic [1:0] req_op,
   input wire logic [ADDR_W-1:0] req_addr,
   input wire logic [DATA_W-1:0] req_data,
   input wire logic adaptive_mode,
   output logic req_ready,
   // user answer
   output logic rsp_valid,
   output logic [DATA_W-1:0] rsp_data,
   output logic rsp_fail,
   // device pins
   output logic dev_select_n,
   output logic out_enable_n,
   output logic [ADDR_W-1:0] addr_pins,
   output logic id_high_voltage_level,
   output logic vcc_prog_en,
   output logic vpp_prog_en,
   input wire logic [DATA_W-1:0] data_pins_i,
   output logic [DATA_W-1:0] data_pins_o,
   output logic data_pins_oe
);
   typedef enum logic [10:0] {
      ST_IDLE = 11'h001, ST_RD_ADDR = 11'h002, ST_RD_OE = 11'h004, ST_FLOAT = 11'h008,
      ST_PG_VCC = 11'h010, ST_PG_VPP = 11'h020, ST_PG_SET = 11'h040, ST_PG_PULSE = 11'h080,
      ST_PG_VFY = 11'h100, ST_PG_VPPOFF = 11'h200, ST_PG_VCCOFF = 11'h400
   } state_e;

   state_e state_q;
   logic [DATA_W-1:0] din_s1_q, din_s2_q, wdata_q;
   logic [7:0] tries_q;
   logic over_q, fail_q, adapt_q, prog_op_q;
   logic [3:0] float_cnt_q;
   logic ld;
   logic [CNT_W-1:0] ld_cnt;
   logic tdone;

   // two-flop synchroniser on the data pins
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         din_s1_q <= '0;
         din_s2_q <= '0;
      end else begin
         din_s1_q <= data_pins_i;
         din_s2_q <= din_s1_q;
      end
   end

   // cycles since output enable last rose, saturating; holds back the data redrive
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         float_cnt_q <= 4'hF;
      end else if (!out_enable_n) begin
         float_cnt_q <= 4'h0;
      end else if (float_cnt_q != 4'hF) begin
         float_cnt_q <= float_cnt_q + 4'h1;
      end
   end

   // delay timer loads on every state entry that needs a wait
   always_comb begin
      ld = 1'b0;
      ld_cnt = '0;
      unique case (state_q)
         ST_IDLE: begin
            ld = req_valid;
            ld_cnt = (req_op == OP_PROG) ? CNT_W'(CYC_SETUP) : CNT_W'(CYC_ACC_OE);
         end
         ST_RD_ADDR: begin
            ld = tdone;
            ld_cnt = CNT_W'(CYC_OE + 2); // allow for synchroniser
         end
         ST_RD_OE, ST_PG_VCC, ST_PG_SET, ST_PG_PULSE, ST_PG_VPPOFF, ST_PG_VFY: begin
            ld = tdone;
            ld_cnt = CNT_W'(CYC_SETUP);
            if (state_q == ST_RD_OE) ld_cnt = CNT_W'(CYC_DF);
            if (state_q == ST_PG_SET) begin
               if (over_q) ld_cnt = CNT_W'(CYC_OVER_STEP);
               else if (adapt_q) ld_cnt = CNT_W'(CYC_ADAPT_PW);
               else ld_cnt = CNT_W'(CYC_FAST_PW);
            end
         end
         ST_PG_VPP: begin
            ld = tdone;
            ld_cnt = CNT_W'(CYC_SETUP);
         end
         ST_FLOAT, ST_PG_VCCOFF: begin
            ld = 1'b0;
            ld_cnt = '0;
         end
      endcase
   end

   eprom_delay u_delay (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .load(ld),
      .count(ld_cnt),
      .done(tdone)
   );

   // sequencer
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_q <= ST_IDLE;
         tries_q <= '0;
         over_q <= 1'b0;
         fail_q <= 1'b0;
         adapt_q <= 1'b0;
         prog_op_q <= 1'b0;
         wdata_q <= ERASED_BYTE;
      end else begin
         unique case (state_q)
            ST_IDLE: if (req_valid) begin
               adapt_q <= adaptive_mode;
               wdata_q <= req_data;
               tries_q <= '0;
               over_q <= 1'b0;
               fail_q <= 1'b0;
               prog_op_q <= (req_op == OP_PROG);
               state_q <= (req_op == OP_PROG) ? ST_PG_VCC : ST_RD_ADDR;
            end
            ST_RD_ADDR: if (tdone) state_q <= ST_RD_OE;
            ST_RD_OE: if (tdone) state_q <= ST_FLOAT;
            ST_FLOAT: if (tdone) state_q <= ST_IDLE;
            ST_PG_VCC: if (tdone) state_q <= ST_PG_VPP;
            ST_PG_VPP: if (tdone) state_q <= ST_PG_SET;
            ST_PG_SET: if (tdone) begin
               state_q <= ST_PG_PULSE;
               tries_q <= tries_q + 8'h01;
            end
            ST_PG_PULSE: if (tdone) state_q <= ST_PG_VFY;
            ST_PG_VFY: if (tdone) begin
               if (over_q) state_q <= ST_PG_VPPOFF;
               else if (din_s2_q == wdata_q) begin
                  if (adapt_q) begin
                     over_q <= 1'b1; // one overprogram pulse
                     state_q <= ST_PG_SET;
                  end else state_q <= ST_PG_VPPOFF;
               end else if (tries_q >= (adapt_q ? ADAPT_RETRY : FAST_RETRY)) begin
                  fail_q <= 1'b1;
                  state_q <= ST_PG_VPPOFF;
               end else state_q <= ST_PG_SET;
            end
            ST_PG_VPPOFF: if (tdone) state_q <= ST_PG_VCCOFF;
            ST_PG_VCCOFF: state_q <= ST_IDLE;
         endcase
      end
   end

   // device pin drive, all registered
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         dev_select_n <= 1'b1;
         out_enable_n <= 1'b1;
         addr_pins <= '0;
         id_high_voltage_level <= 1'b0;
         vcc_prog_en <= 1'b0;
         vpp_prog_en <= 1'b0;
         data_pins_o <= '0;
         data_pins_oe <= 1'b0;
      end else begin
         if (state_q == ST_IDLE && req_valid) begin
            // signature: id bit at high voltage, only id select bit kept
            addr_pins <= (req_op == OP_SIG) ? {{(ADDR_W-1){1'b0}}, req_addr[0]} : req_addr;
            id_high_voltage_level <= (req_op == OP_SIG);
            dev_select_n <= (req_op == OP_PROG);
            out_enable_n <= 1'b1;
         end
         if (state_q == ST_RD_ADDR && tdone) out_enable_n <= 1'b0;
         if (state_q == ST_RD_OE && tdone) begin
            out_enable_n <= 1'b1;
            dev_select_n <= 1'b1;
         end
         if (state_q == ST_FLOAT && tdone) id_high_voltage_level <= 1'b0;
         if (state_q == ST_PG_VCC) vcc_prog_en <= 1'b1;
         if (state_q == ST_PG_VPP) begin
            vpp_prog_en <= 1'b1; // both selects high meanwhile
            data_pins_o <= wdata_q;
            data_pins_oe <= 1'b1;
         end
         if (state_q == ST_PG_SET) begin
            out_enable_n <= 1'b1;
            if (tdone) dev_select_n <= 1'b0;
         end
         if (state_q == ST_PG_SET && !tdone && out_enable_n && !data_pins_oe && float_cnt_q >= 4'(CYC_DF)) begin
            data_pins_oe <= 1'b1; // redrive after float wait
         end
         if (state_q == ST_PG_PULSE && tdone) begin
            dev_select_n <= 1'b1;
            data_pins_oe <= 1'b0; // release before verify
         end
         if (state_q == ST_PG_VFY) out_enable_n <= tdone;
         if (state_q == ST_PG_VPPOFF) out_enable_n <= 1'b1;
         if (state_q == ST_PG_VPPOFF && tdone) vpp_prog_en <= 1'b0;
         if (state_q == ST_PG_VCCOFF) vcc_prog_en <= 1'b0;
      end
   end

   // user answer
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         req_ready <= 1'b0;
         rsp_valid <= 1'b0;
         rsp_data <= '0;
         rsp_fail <= 1'b0;
      end else begin
         req_ready <= (state_q == ST_IDLE) && !req_valid;
         rsp_valid <= 1'b0;
         if (state_q == ST_RD_OE && tdone) begin
            rsp_valid <= 1'b1;
            rsp_data <= din_s2_q;
            rsp_fail <= 1'b0;
         end
         if (state_q == ST_PG_VCCOFF && prog_op_q) begin
            rsp_valid <= 1'b1;
            rsp_data <= wdata_q;
            rsp_fail <= fail_q;
         end
      end
   end
endmodule

// ### rtl/eprom_host_pkg.sv
// package: timing counts, request op codes and sequencer constants for the eprom host controller
package eprom_host_pkg;
   localparam int CLK_MHZ = 125;
   localparam int ADDR_W = 15;
   localparam int DATA_W = 8;
   // read timing in ns, program setup and pulse timing in us
   localparam int T_ACC_NS = 120;
   localparam int T_OE_NS = 50;
   localparam int T_DF_NS = 50;
   localparam int T_SETUP_US = 2;
   localparam int T_FAST_PW_US = 100;
   localparam int T_ADAPT_PW_US = 1000;
   localparam int T_OVER_MIN_US = 2850;
   localparam int T_OVER_MAX_US = 78500;
   localparam int T_OVER_STEP_US = 3000;
   localparam int CYC_ACC_OE = ((T_ACC_NS - T_OE_NS) * CLK_MHZ + 999) / 1000;
   localparam int CYC_OE = (T_OE_NS * CLK_MHZ + 999) / 1000;
   localparam int CYC_DF = (T_DF_NS * CLK_MHZ + 999) / 1000;
   localparam int CYC_SETUP = T_SETUP_US * CLK_MHZ;
   localparam int CYC_FAST_PW = T_FAST_PW_US * CLK_MHZ;
   localparam int CYC_ADAPT_PW = T_ADAPT_PW_US * CLK_MHZ;
   localparam int CYC_OVER_STEP = T_OVER_STEP_US * CLK_MHZ;
   localparam int CNT_W = 24;
   localparam logic [7:0] FAST_RETRY = 8'h19;
   localparam logic [7:0] ADAPT_RETRY = 8'h19;
   localparam logic [1:0] OP_READ = 2'h0;
   localparam logic [1:0] OP_SIG = 2'h1;
   localparam logic [1:0] OP_PROG = 2'h2;
   localparam logic [DATA_W-1:0] ERASED_BYTE = 8'hFF;
endpackage

// ### rtl/eprom_delay.sv
// one-shot delay counter: done pulses once after the loaded count expires
`timescale 1ns/1ps
module eprom_delay
   import eprom_host_pkg::*;
(
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst_n,
   // control
   input wire logic load,
   input wire logic [CNT_W-1:0] count,
   output logic done
);
   logic [CNT_W-1:0] cnt_q;
   logic run_q;

   // count down from the load value, flag on reaching one
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_q <= '0;
         run_q <= 1'b0;
         done <= 1'b0;
      end else if (load) begin
         cnt_q <= count;
         run_q <= 1'b1;
         done <= 1'b0;
      end else if (run_q && cnt_q <= CNT_W'(1)) begin
         run_q <= 1'b0;
         done <= 1'b1;
      end else begin
         cnt_q <= cnt_q - CNT_W'(1);
         done <= 1'b0;
      end
   end
endmodule

// ### test/eprom_host_assertions.sv
// checker: supply order, pulse width and pin timing of the eprom host controller
`timescale 1ns/1ps
module eprom_host_assertions
   import eprom_host_pkg::*;
(
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst_n,
   // watched ports
   input wire logic adaptive_mode,
   input wire logic dev_select_n,
   input wire logic out_enable_n,
   input wire logic [ADDR_W-1:0] addr_pins,
   input wire logic id_high_voltage_level,
   input wire logic vcc_prog_en,
   input wire logic vpp_prog_en,
   input wire logic data_pins_oe
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   logic [CNT_W-1:0] low_cnt_q;
   // length of the current select-low pulse while vpp is up
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) low_cnt_q <= '0;
      else if (dev_select_n) low_cnt_q <= '0;
      else if (vpp_prog_en) low_cnt_q <= low_cnt_q + 1'b1;
   end
   chk_supply_order: assert property (vpp_prog_en |-> vcc_prog_en)
      else $error("programming supply up without low supply");
   chk_prog_entry: assert property ($rose(vpp_prog_en) |-> dev_select_n && out_enable_n)
      else $error("programming supply raised while selected");
   chk_low_first: assert property ($rose(vcc_prog_en) |-> !vpp_prog_en)
      else $error("low supply raised after programming supply");
   chk_sig_address: assert property (id_high_voltage_level |->
      addr_pins[14:10] == 5'h00 && addr_pins[8:1] == 8'h00 && !vpp_prog_en)
      else $error("signature address lines not held low");
   chk_verify_cycle: assert property (vpp_prog_en && !out_enable_n |-> dev_select_n && !data_pins_oe)
      else $error("verify cycle with select low or data driven");
   chk_fast_width: assert property ($rose(dev_select_n) && vpp_prog_en && !adaptive_mode |->
      low_cnt_q >= 24'd11875 && low_cnt_q <= 24'd13125)
      else $error("fast programming pulse width out of range");
   chk_adapt_width: assert property ($rose(dev_select_n) && vpp_prog_en && adaptive_mode |->
      low_cnt_q inside {[24'd118750:24'd131250], [24'd356250:24'd9812500]})
      else $error("adaptive programming pulse width out of range");
   chk_float_wait: assert property ($rose(out_enable_n) |-> !data_pins_oe [*7])
      else $error("data driven before float delay");
   chk_read_hold: assert property ($fell(out_enable_n) && !vpp_prog_en |->
      (!dev_select_n && $stable(addr_pins)) [*8])
      else $error("read enable window too short or address moved");
endmodule

// ### test/eprom_device_model.sv
// behavioural model of the 32k x 8 uv eprom on the host's pins
`timescale 1ns/1ps
module eprom_device_model
   import eprom_host_pkg::*;
#(
   parameter logic [DATA_W-1:0] MAKER_CODE = 8'hA5, // arbitrary value
   parameter logic [DATA_W-1:0] PART_CODE = 8'h5A // arbitrary value
)
(
   // device pins
   input wire logic select_n,
   input wire logic oe_n,
   input wire logic [ADDR_W-1:0] addr,
   input wire logic hv,
   input wire logic vpp,
   input wire logic [DATA_W-1:0] din,
   output logic [DATA_W-1:0] dout
);
   logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];
   logic [DATA_W-1:0] last_q;
   logic [DATA_W-1:0] word;
   logic drive;
   logic oe_late_n;
   // erased array reads all ones
   initial begin
      for (int i = 0; i < (1<<ADDR_W); i++) mem[i] = ERASED_BYTE;
      last_q = 8'h00;
   end
   // program pulse only clears bits where data is zero
   always @(negedge select_n) begin
      if (vpp && oe_n) mem[addr] = mem[addr] & din;
   end
   // enable seen one output delay late: data is not valid before that
   assign #(T_OE_NS) oe_late_n = oe_n;
   // output drive; a released bus shows the inverse of its last value
   always @* begin
      drive = !oe_n && !oe_late_n && (vpp ? select_n : !select_n);
      word = mem[addr];
      if (!vpp && hv) word = (addr[ADDR_W-1:1] != '0) ? ~MAKER_CODE : (addr[0] ? PART_CODE : MAKER_CODE);
      dout = drive ? word : ~last_q;
   end
   // remember the last driven byte
   always @(drive or word) begin
      if (drive) last_q = word;
   end
endmodule

// ### test/tb_eprom_host.sv
// testbench: reads, signature reads and fast programming against the device model
`timescale 1ns/1ps
module tb_eprom_host
   import eprom_host_pkg::*;
;
   logic sys_clk = 1'b0;
   logic rst_n = 1'b0;
   logic req_valid = 1'b0;
   logic [1:0] req_op = OP_READ;
   logic [ADDR_W-1:0] req_addr = '0;
   logic [DATA_W-1:0] req_data = '0;
   logic adaptive_mode = 1'b0;
   logic req_ready, rsp_valid, rsp_fail, dev_select_n, out_enable_n, id_high_voltage_level;
   logic vcc_prog_en, vpp_prog_en, data_pins_oe;
   logic [DATA_W-1:0] rsp_data, data_pins_o, dev_dout, bus_data;
   logic [ADDR_W-1:0] addr_pins;
   int n_errors = 0;
   int check_count = 0;
   // clock and shared data wire
   always #4 sys_clk = ~sys_clk;
   assign bus_data = data_pins_oe ? data_pins_o : dev_dout;
   eprom_host u_eprom_host (.sys_clk(sys_clk), .rst_n(rst_n), .req_valid(req_valid), .req_op(req_op),
      .req_addr(req_addr), .req_data(req_data), .adaptive_mode(adaptive_mode), .req_ready(req_ready),
      .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_fail(rsp_fail), .dev_select_n(dev_select_n),
      .out_enable_n(out_enable_n), .addr_pins(addr_pins), .id_high_voltage_level(id_high_voltage_level),
      .vcc_prog_en(vcc_prog_en), .vpp_prog_en(vpp_prog_en), .data_pins_i(bus_data),
      .data_pins_o(data_pins_o), .data_pins_oe(data_pins_oe));
   eprom_device_model u_eprom_device_model (.select_n(dev_select_n), .oe_n(out_enable_n), .addr(addr_pins),
      .hv(id_high_voltage_level), .vpp(vpp_prog_en), .din(bus_data), .dout(dev_dout));
   task automatic chk(input string name, input logic [DATA_W-1:0] exp, input logic [DATA_W-1:0] got);
      check_count++;
      if (got !== exp) begin
         $display("unexpected %s expected %h seen %h", name, exp, got);
         n_errors++;
      end
   endtask
   // one request, waits for the answer pulse under a bound
   task automatic run_req(input logic [1:0] op, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      int n;
      n = 0;
      while (req_ready !== 1'b1 && n < 100) begin
         @(negedge sys_clk);
         n++;
      end
      chk("ready before request", 8'h01, {7'h00, req_ready});
      req_op = op;
      req_addr = a;
      req_data = d;
      req_valid = 1'b1;
      @(negedge sys_clk);
      req_valid = 1'b0;
      chk("ready while busy", 8'h00, {7'h00, req_ready});
      n = 0;
      while (rsp_valid !== 1'b1 && n < 20000) begin
         @(negedge sys_clk);
         n++;
      end
      chk("answer arrived", 8'h01, {7'h00, rsp_valid});
   endtask
   task automatic test_idle_pins();
      chk("idle select", 8'h01, {7'h00, dev_select_n});
      chk("idle enable", 8'h01, {7'h00, out_enable_n});
      chk("idle vpp", 8'h00, {7'h00, vpp_prog_en});
   endtask
   task automatic test_read_erased();
      adaptive_mode = 1'b1;
      run_req(OP_READ, 15'h7FFF, 8'h00);
      chk("erased byte", ERASED_BYTE, rsp_data);
      adaptive_mode = 1'b0;
   endtask
   task automatic test_signature();
      run_req(OP_SIG, 15'h0000, 8'h00);
      chk("maker code", 8'hA5, rsp_data);
      run_req(OP_SIG, 15'h0001, 8'h00);
      chk("part code", 8'h5A, rsp_data);
   endtask
   task automatic test_program();
      run_req(OP_PROG, 15'h1234, 8'hA6);
      chk("program fail flag", 8'h00, {7'h00, rsp_fail});
      chk("verified byte", 8'hA6, rsp_data);
      chk("supplies off", 8'h00, {6'h00, vcc_prog_en, vpp_prog_en});
      run_req(OP_READ, 15'h1234, 8'h00);
      chk("read back", 8'hA6, rsp_data);
   endtask
   task automatic print_verdict();
      if (n_errors == 0 && check_count > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   // watchdog
   initial begin
      #(60000 * 8);
      n_errors++;
      print_verdict();
   end
   // main sequence
   initial begin
      repeat (3) @(negedge sys_clk);
      rst_n = 1'b1;
      repeat (2) @(negedge sys_clk);
      test_idle_pins();
      test_read_erased();
      test_signature();
      test_program();
      print_verdict();
   end
endmodule
bind eprom_host eprom_host_assertions u_eprom_host_assertions (.sys_clk(sys_clk), .rst_n(rst_n),
   .adaptive_mode(adaptive_mode), .dev_select_n(dev_select_n), .out_enable_n(out_enable_n),
   .addr_pins(addr_pins), .id_high_voltage_level(id_high_voltage_level), .vcc_prog_en(vcc_prog_en),
   .vpp_prog_en(vpp_prog_en), .data_pins_oe(data_pins_oe));
